// file: design/fcx_cyc_if.sv
`timescale 1ns/1ns
interface fcx_cyc_if;
	logic        req;
	logic        wr;
	logic [16:0] addr;
	logic [7:0]  wdata;
	logic        ack;
	logic [7:0]  rdata;

	modport init (output req, output wr, output addr, output wdata, input ack, input rdata);
	modport eng  (input req, input wr, input addr, input wdata, output ack, output rdata);
endinterface

// file: design/fcx_cycle.sv
`timescale 1ns/1ns
module fcx_cycle import fcx_pkg::*; (
	// Clock and reset.
	input  wire logic        i_clk_sys,
	input  wire logic        i_rst_n,
	// Request side.
	fcx_cyc_if.eng           cyc,
	// Flash pins.
	output logic             o_ce_n,
	output logic             o_oe_n,
	output logic             o_we_n,
	output logic [16:0]      o_addr,
	output logic [7:0]       o_dq_out,
	output logic             o_dq_oe,
	input  wire logic [7:0]  i_dq_in
);

	typedef enum logic [2:0] {
		C_IDLE  = 3'b000,
		C_WLOW  = 3'b001,
		C_WHOLD = 3'b010,
		C_RWAIT = 3'b011,
		C_REC   = 3'b100
	} fcx_cst_e;

	typedef struct packed {
		fcx_cst_e    st;
		logic [3:0]  cnt;
		logic        ce_n;
		logic        oe_n;
		logic        we_n;
		logic [16:0] addr;
		logic [7:0]  dq;
		logic        dq_oe;
		logic [7:0]  rdata;
		logic        ack;
	} fcx_cyc_s;

	fcx_cyc_s r;
	fcx_cyc_s next_r;

	// One bus cycle: write pulses WE with OE high, read holds CE and OE low for the access time.
	always_comb begin
		next_r = r;
		next_r.ack = 1'b0;
		case (r.st)
			C_IDLE: begin
				if (cyc.req && !r.ack) begin
					next_r.addr = cyc.addr;
					next_r.ce_n = 1'b0;
					if (cyc.wr) begin
						next_r.oe_n  = 1'b1;
						next_r.we_n  = 1'b0;
						next_r.dq    = cyc.wdata;
						next_r.dq_oe = 1'b1;
						next_r.cnt   = 4'(CNT_WP);
						next_r.st    = C_WLOW;
					end else begin
						next_r.we_n = 1'b1;
						next_r.oe_n = 1'b0;
						next_r.cnt  = 4'(CNT_RD);
						next_r.st   = C_RWAIT;
					end
				end
			end
			C_WLOW: begin
				if (r.cnt == 4'h1) begin
					next_r.we_n = 1'b1; // Data is taken on this rising edge.
					next_r.st   = C_WHOLD;
				end else begin
					next_r.cnt = r.cnt - 4'h1;
				end
			end
			C_WHOLD: begin
				next_r.ce_n  = 1'b1;
				next_r.dq_oe = 1'b0;
				next_r.cnt   = 4'(CNT_REC);
				next_r.st    = C_REC;
			end
			C_RWAIT: begin
				if (r.cnt == 4'h1) begin
					next_r.rdata = i_dq_in;
					next_r.ce_n  = 1'b1;
					next_r.oe_n  = 1'b1;
					next_r.cnt   = 4'(CNT_REC);
					next_r.st    = C_REC;
				end else begin
					next_r.cnt = r.cnt - 4'h1;
				end
			end
			C_REC: begin
				if (r.cnt == 4'h1) begin
					next_r.ack = 1'b1;
					next_r.st  = C_IDLE;
				end else begin
					next_r.cnt = r.cnt - 4'h1;
				end
			end
			default: begin
				next_r = '0;
				next_r.ce_n = 1'b1;
				next_r.oe_n = 1'b1;
				next_r.we_n = 1'b1;
			end
		endcase
	end

	// State register; all strobes idle high after reset.
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			r      <= '0;
			r.ce_n <= 1'b1;
			r.oe_n <= 1'b1;
			r.we_n <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	// Outputs straight from the state register.
	assign o_ce_n    = r.ce_n;
	assign o_oe_n    = r.oe_n;
	assign o_we_n    = r.we_n;
	assign o_addr    = r.addr;
	assign o_dq_out  = r.dq;
	assign o_dq_oe   = r.dq_oe;
	assign cyc.ack   = r.ack;
	assign cyc.rdata = r.rdata;

	// Cycles spent with CE low and OE low, checked at the sampling edge.
	logic [3:0] rd_low;
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rd_low <= 4'h0;
		end else if (!r.ce_n && !r.oe_n) begin
			rd_low <= rd_low + 4'h1;
		end else begin
			rd_low <= 4'h0;
		end
	end

	a_read_levels: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(!o_ce_n && !o_oe_n) |-> o_we_n) else $error("WE low during a read cycle");
	a_write_levels: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		!o_we_n |-> (!o_ce_n && o_oe_n && o_dq_oe)) else $error("write strobe without CE low and OE high");
	a_no_bus_fight: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		o_dq_oe |-> o_oe_n) else $error("host drives data while flash may drive");
	a_access_wait: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(r.st == C_RWAIT && r.cnt == 4'h1) |-> (rd_low == 4'(CNT_RD - 1))) else $error("read sampled too early");
	a_idle_deselect: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(r.st == C_IDLE) |-> (o_ce_n && o_we_n && !o_dq_oe)) else $error("flash selected while idle");
	a_write_release: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		$rose(o_we_n) |=> (o_ce_n && !o_dq_oe)) else $error("write not released after WE rise");

	c_write_cycle: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n) $fell(o_we_n));
	c_read_cycle: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n) $fell(o_oe_n));

endmodule

// file: design/fcx_host.sv
`timescale 1ns/1ns
// Functional notes
// - Reads drive chip select and output gate low, write strobe high.
// - Command writes drive write strobe and chip select low, output gate high.
// - Bypass program takes two write cycles, standard program four.
// - After standby, wait full chip select access time before sampling.
// - Programmer autoselect: high voltage on A9, A6 low, A1/A0 select code.
module fcx_host import fcx_pkg::*; #(
	parameter int POLL_MAX = 65535
) (
	// Clock and reset.
	input  wire logic        i_clk_sys,
	input  wire logic        i_rst_n,
	// Command port.
	input  wire logic        i_req,
	input  wire logic [3:0]  i_op,
	input  wire logic [16:0] i_addr,
	input  wire logic [7:0]  i_wdata,
	output logic             o_busy,
	output logic             o_done,
	output logic             o_err,
	output logic [7:0]       o_rdata,
	// Flash pins.
	output logic             o_ce_n,
	output logic             o_oe_n,
	output logic             o_we_n,
	output logic [16:0]      o_addr,
	output logic [7:0]       o_dq_out,
	output logic             o_dq_oe,
	input  wire logic [7:0]  i_dq_in,
	output logic             o_id_high_voltage
);

	typedef enum logic [2:0] {
		M_IDLE  = 3'b000,
		M_SEQ   = 3'b001,
		M_WAIT  = 3'b010,
		M_POLL  = 3'b011,
		M_PWAIT = 3'b100
	} fcx_mst_e;

	typedef struct packed {
		fcx_mst_e    st;
		fcx_op_e     op;
		logic [2:0]  step;
		logic [16:0] addr;
		logic [7:0]  wdata;
		logic        req;
		logic        wr;
		logic [16:0] caddr;
		logic [7:0]  cdata;
		logic [7:0]  rdata;
		logic        first;
		logic [15:0] pcnt;
		logic        busy;
		logic        done;
		logic        err;
		logic        hv;
	} fcx_host_s;

	fcx_host_s r;
	fcx_host_s next_r;

	fcx_cyc_if cyc ();

	// Number of bus cycles in each operation's command sequence.
	function automatic logic [2:0] seq_len(input fcx_op_e op);
		case (op)
			OP_PROG:       seq_len = 3'h4;
			OP_BYP_PROG:   seq_len = 3'h2;
			OP_SEC_ERASE:  seq_len = 3'h6;
			OP_CHIP_ERASE: seq_len = 3'h6;
			OP_AUTOSEL:    seq_len = 3'h3;
			OP_BYP_ENTER:  seq_len = 3'h3;
			OP_BYP_EXIT:   seq_len = 3'h2;
			default:       seq_len = 3'h1;
		endcase
	endfunction

	// Whether an operation ends with status polling.
	function automatic logic needs_poll(input fcx_op_e op);
		needs_poll = (op == OP_PROG) || (op == OP_BYP_PROG) || (op == OP_SEC_ERASE) || (op == OP_CHIP_ERASE);
	endfunction

	// Address of the first byte of the sector holding an address.
	function automatic logic [16:0] sect_base(input logic [16:0] a);
		sect_base = {a[SECT_HI:SECT_LO], 14'h0000};
	endfunction

	// Write cycle of a sequence as {address, data}; the two unlock writes lead each guarded sequence.
	function automatic logic [24:0] seq_cyc(input fcx_op_e op, input logic [2:0] step,
			input logic [16:0] a, input logic [7:0] d);
		logic [7:0] cmd;
		cmd = CMD_PROG;
		case (op)
			OP_AUTOSEL:    cmd = CMD_AUTO;
			OP_BYP_ENTER:  cmd = CMD_BYP;
			default:       cmd = CMD_ERASE;
		endcase
		if (op == OP_PROG) begin
			cmd = CMD_PROG;
		end
		case (step)
			3'h0:    seq_cyc = {UNL1_ADDR, UNL1_DATA};
			3'h1:    seq_cyc = {UNL2_ADDR, UNL2_DATA};
			3'h2:    seq_cyc = {UNL1_ADDR, cmd};
			3'h3:    seq_cyc = (op == OP_PROG) ? {a, d} : {UNL1_ADDR, UNL1_DATA};
			3'h4:    seq_cyc = {UNL2_ADDR, UNL2_DATA};
			default: seq_cyc = (op == OP_CHIP_ERASE) ? {UNL1_ADDR, CMD_CHIP} : {sect_base(a), CMD_SECT};
		endcase
		case (op)
			OP_BYP_PROG:   seq_cyc = (step == 3'h0) ? {UNL1_ADDR, CMD_PROG} : {a, d};
			OP_ADD_SECTOR: seq_cyc = {sect_base(a), CMD_SECT};
			OP_RESET:      seq_cyc = {17'h00000, CMD_RESET};
			OP_BYP_EXIT:   seq_cyc = (step == 3'h0) ? {17'h00000, CMD_AUTO} : {17'h00000, CMD_BYPX2};
			default:       seq_cyc = seq_cyc;
		endcase
	endfunction

	// Command sequencing and toggle-bit status polling.
	always_comb begin
		next_r = r;
		next_r.done = 1'b0;
		case (r.st)
			M_IDLE: begin
				if (i_req) begin
					next_r.op    = fcx_op_e'(i_op);
					next_r.addr  = i_addr;
					next_r.wdata = i_wdata;
					next_r.step  = 3'h0;
					next_r.busy  = 1'b1;
					next_r.err   = 1'b0;
					next_r.pcnt  = 16'h0000;
					if (fcx_op_e'(i_op) == OP_HV_READ) begin
						next_r.hv = 1'b1;
						next_r.addr[A6_POS] = 1'b0;
					end
					next_r.st = M_SEQ;
				end
			end
			M_SEQ: begin
				next_r.req = 1'b1;
				if ((r.op == OP_READ) || (r.op == OP_HV_READ)) begin
					next_r.wr    = 1'b0;
					next_r.caddr = r.addr;
				end else begin
					next_r.wr = 1'b1;
					{next_r.caddr, next_r.cdata} = seq_cyc(r.op, r.step, r.addr, r.wdata);
				end
				next_r.st = M_WAIT;
			end
			M_WAIT: begin
				if (cyc.ack) begin
					next_r.req = 1'b0;
					if (!r.wr) begin
						next_r.rdata = cyc.rdata;
					end
					if (r.step == seq_len(r.op) - 3'h1) begin
						if (needs_poll(r.op)) begin
							next_r.first = 1'b1;
							next_r.st    = M_POLL;
						end else begin
							next_r.busy = 1'b0;
							next_r.done = 1'b1;
							next_r.hv   = 1'b0;
							next_r.st   = M_IDLE;
						end
					end else begin
						next_r.step = r.step + 3'h1;
						next_r.st   = M_SEQ;
					end
				end
			end
			M_POLL: begin
				next_r.req   = 1'b1;
				next_r.wr    = 1'b0;
				next_r.caddr = r.addr;
				next_r.st    = M_PWAIT;
			end
			M_PWAIT: begin
				if (cyc.ack) begin
					next_r.req   = 1'b0;
					next_r.rdata = cyc.rdata;
					next_r.first = 1'b0;
					next_r.pcnt  = r.pcnt + 16'h0001;
					if (!r.first && (cyc.rdata[TOGL_BIT] == r.rdata[TOGL_BIT])) begin
						next_r.busy = 1'b0; // Toggle bit stopped, operation over.
						next_r.done = 1'b1;
						next_r.st   = M_IDLE;
					end else if (r.pcnt == 16'(POLL_MAX)) begin
						next_r.err  = 1'b1;
						next_r.busy = 1'b0;
						next_r.done = 1'b1;
						next_r.st   = M_IDLE;
					end else begin
						next_r.st = M_POLL;
					end
				end
			end
			default: begin
				next_r = '0;
			end
		endcase
	end

	// State register.
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	// Cycle engine requests from the state register.
	assign cyc.req   = r.req;
	assign cyc.wr    = r.wr;
	assign cyc.addr  = r.caddr;
	assign cyc.wdata = r.cdata;

	// Outputs straight from flops.
	assign o_busy            = r.busy;
	assign o_done            = r.done;
	assign o_err             = r.err;
	assign o_rdata           = r.rdata;
	assign o_id_high_voltage = r.hv;

	fcx_cycle u_cycle (
		.i_clk_sys (i_clk_sys),
		.i_rst_n   (i_rst_n),
		.cyc       (cyc.eng),
		.o_ce_n    (o_ce_n),
		.o_oe_n    (o_oe_n),
		.o_we_n    (o_we_n),
		.o_addr    (o_addr),
		.o_dq_out  (o_dq_out),
		.o_dq_oe   (o_dq_oe),
		.i_dq_in   (i_dq_in)
	);

	// Write cycles issued during the current operation.
	logic [2:0] wr_seen;
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wr_seen <= 3'h0;
		end else if (r.st == M_IDLE) begin
			wr_seen <= 3'h0;
		end else if ($fell(o_we_n)) begin
			wr_seen <= wr_seen + 3'h1;
		end
	end

	a_bypass_two: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(r.st == M_POLL && r.first && r.op == OP_BYP_PROG) |-> (wr_seen == 3'h2)) else $error("bypass program not two writes");
	a_prog_four: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(r.st == M_POLL && r.first && r.op == OP_PROG) |-> (wr_seen == 3'h4)) else $error("program not four writes");
	a_hv_a6_low: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(o_id_high_voltage && !o_ce_n) |-> (!o_addr[A6_POS] && o_we_n)) else $error("A6 high under high voltage read");
	a_unlock_first: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(r.op == OP_PROG && r.step == 3'h0 && $fell(o_we_n)) |-> (o_dq_out == UNL1_DATA && o_addr == UNL1_ADDR))
		else $error("program sequence without unlock write");

	c_prog_done: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n) o_done && r.op == OP_PROG);
	c_erase_done: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n) o_done && r.op == OP_CHIP_ERASE);
	c_hv_read: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n) o_done && r.op == OP_HV_READ);

endmodule

// file: design/fcx_pkg.sv
package fcx_pkg;

	// Bus widths of the flash part.
	localparam int ADDR_W = 17;
	localparam int DATA_W = 8;

	// System clock period and the pin timing the host must honour.
	localparam int CLK_NS    = 40;
	localparam int ADDRESS_ACCESS_TIME_NS  = 55;
	localparam int T_CE_NS   = 55;
	localparam int T_OE_NS   = 30;
	localparam int T_WP_NS   = 35;
	localparam int T_WPH_NS  = 30;

	// Cycle counts, least times rounded up, never below one.
	localparam int RD_NS   = (ADDRESS_ACCESS_TIME_NS > T_CE_NS) ? ADDRESS_ACCESS_TIME_NS : T_CE_NS;
	localparam int CNT_RD  = ((RD_NS + CLK_NS - 1) / CLK_NS < 1) ? 1 : (RD_NS + CLK_NS - 1) / CLK_NS;
	localparam int CNT_WP  = ((T_WP_NS + CLK_NS - 1) / CLK_NS < 1) ? 1 : (T_WP_NS + CLK_NS - 1) / CLK_NS;
	localparam int CNT_REC = ((T_WPH_NS + CLK_NS - 1) / CLK_NS < 1) ? 1 : (T_WPH_NS + CLK_NS - 1) / CLK_NS;

	// Unlock cycle addresses and data, and command codes.
	localparam logic [16:0] UNL1_ADDR = 17'h00555;
	localparam logic [16:0] UNL2_ADDR = 17'h002AA;
	localparam logic [7:0]  UNL1_DATA = 8'hAA;
	localparam logic [7:0]  UNL2_DATA = 8'h55;
	localparam logic [7:0]  CMD_PROG  = 8'hA0;
	localparam logic [7:0]  CMD_ERASE = 8'h80;
	localparam logic [7:0]  CMD_SECT  = 8'h30;
	localparam logic [7:0]  CMD_CHIP  = 8'h10;
	localparam logic [7:0]  CMD_AUTO  = 8'h90;
	localparam logic [7:0]  CMD_RESET = 8'hF0;
	localparam logic [7:0]  CMD_BYP   = 8'h20;
	localparam logic [7:0]  CMD_BYPX2 = 8'h00;

	// Address fields: sector code on the top bits, autoselect selects; status toggle bit of the data byte.
	localparam int SECT_HI  = 16;
	localparam int SECT_LO  = 14;
	localparam int A6_POS   = 6;
	localparam int TOGL_BIT = 6;

	// Host operations.
	typedef enum logic [3:0] {
		OP_READ       = 4'h0,
		OP_PROG       = 4'h1,
		OP_BYP_PROG   = 4'h2,
		OP_SEC_ERASE  = 4'h3,
		OP_CHIP_ERASE = 4'h4,
		OP_ADD_SECTOR = 4'h5,
		OP_AUTOSEL    = 4'h6,
		OP_RESET      = 4'h7,
		OP_BYP_ENTER  = 4'h8,
		OP_BYP_EXIT   = 4'h9,
		OP_HV_READ    = 4'hA
	} fcx_op_e;

endpackage

// file: verification/fcx_flash_model.sv
`timescale 1ns/1ns
module fcx_flash_model import fcx_pkg::*; #(
	parameter int         BUSY_CYC = 20,
	parameter logic [7:0] MFR_CODE = 8'h3C, // Arbitrary value.
	parameter logic [7:0] DEV_CODE = 8'hC3  // Arbitrary value.
) (
	// Clock and flash pins.
	input  wire logic        i_clk_sys,
	input  wire logic        i_ce_n,
	input  wire logic        i_oe_n,
	input  wire logic        i_we_n,
	input  wire logic [16:0] i_addr,
	input  wire logic [7:0]  i_dq,
	input  wire logic        i_id_high_voltage,
	// Sector protection set by the bench acting as programmer.
	input  wire logic [7:0]  i_prot,
	output logic [7:0]       o_dq
);
	logic [7:0]  mem [0:131071];
	logic [2:0]  step;
	logic        auto, byp, arm, rd_d, wr_d, tgl, rd, wr, rd_ok;
	logic [16:0] la, oa;
	logic [7:0]  ld, od, last, rd_v, ers;
	int          busy, age;

	// Chip select gates both strobes; a write also needs the output gate high.
	assign rd = !i_ce_n && !i_oe_n;
	assign wr = !i_ce_n && !i_we_n && i_oe_n;

	// Power-up state is plain array read over an erased array.
	initial begin
		for (int i = 0; i < 131072; i++) mem[i] = 8'hFF;
		{step, auto, byp, arm, rd_d, wr_d, tgl, last, ers, od} = '0;
		busy = 0;
		age = 0;
	end

	// Status while busy, codes in autoselect, array data otherwise.
	always_comb begin
		if (busy > 0) rd_v = {~od[7], tgl, 6'h00};
		else if (auto || (i_id_high_voltage && !i_addr[A6_POS])) begin
			rd_v = i_addr[1] ? {7'h00, i_prot[i_addr[16:14]]} : (i_addr[0] ? DEV_CODE : MFR_CODE);
		end else rd_v = mem[i_addr];
	end

	// Data is valid only once the slower access time has passed; a released bus shows the inverse of the last value.
	assign rd_ok = rd && ((age + 1) * CLK_NS >= RD_NS);
	assign o_dq = rd_ok ? rd_v : ~last;

	// Command decoding and the embedded operations.
	always @(posedge i_clk_sys) begin
		rd_d <= rd;
		wr_d <= wr;
		age <= rd ? age + 1 : 0;
		if (rd && !rd_d) tgl <= !tgl;
		if (rd_ok) last <= rd_v;
		if (wr) begin
			la <= i_addr;
			ld <= i_dq;
		end
		if (busy > 0) begin
			busy <= busy - 1;
			if (busy == 1 && ers != 8'h00) begin
				for (int i = 0; i < 131072; i++) if (ers[i >> 14]) mem[i] <= 8'hFF;
			end else if (busy == 1) mem[oa] <= mem[oa] & od;
		end else if (wr_d && !wr) begin
			if (arm) begin
				arm <= 1'b0;
				step <= 3'd0;
				if (!i_prot[la[16:14]]) begin
					busy <= BUSY_CYC;
					od <= ld;
					oa <= la;
					ers <= 8'h00;
				end
			end else if (ld == CMD_RESET) begin
				step <= 3'd0;
				auto <= 1'b0;
			end else if (byp) begin
				if (step == 3'd6 && ld == CMD_BYPX2) byp <= 1'b0;
				step <= (ld == CMD_AUTO) ? 3'd6 : 3'd0;
				arm <= (ld == CMD_PROG);
			end else begin
				case (step)
					3'd0: step <= (la == UNL1_ADDR && ld == UNL1_DATA) ? 3'd1 : 3'd0;
					3'd1: step <= (la == UNL2_ADDR && ld == UNL2_DATA) ? 3'd2 : 3'd0;
					3'd3: step <= (la == UNL1_ADDR && ld == UNL1_DATA) ? 3'd4 : 3'd0;
					3'd4: step <= (la == UNL2_ADDR && ld == UNL2_DATA) ? 3'd5 : 3'd0;
					3'd2: begin
						step <= (la == UNL1_ADDR && ld == CMD_ERASE) ? 3'd3 : 3'd0;
						arm <= (la == UNL1_ADDR && ld == CMD_PROG);
						if (la == UNL1_ADDR && ld == CMD_AUTO) auto <= 1'b1;
						if (la == UNL1_ADDR && ld == CMD_BYP) byp <= 1'b1;
					end
					default: begin
						step <= 3'd0;
						od <= 8'hFF;
						if (ld == CMD_CHIP && la == UNL1_ADDR) ers <= ~i_prot;
						else if (ld == CMD_SECT) ers <= (8'h01 << la[16:14]) & ~i_prot;
						if ((ld == CMD_CHIP && la == UNL1_ADDR) || ld == CMD_SECT) busy <= BUSY_CYC;
					end
				endcase
			end
		end
	end
endmodule

// file: verification/test_parallel_flash_bus_modes.sv
`timescale 1ns/1ns
module test_parallel_flash_bus_modes import fcx_pkg::*;;
	localparam logic [7:0] MFR = 8'h3C; // Arbitrary value.
	localparam logic [7:0] DEV = 8'hC3; // Arbitrary value.
	logic        i_clk_sys = 1'b0;
	logic        i_rst_n, i_req, o_busy, o_done, o_err, o_ce_n, o_oe_n, o_we_n, o_dq_oe, o_hv;
	logic [3:0]  i_op;
	logic [16:0] i_addr, o_addr, a;
	logic [7:0]  i_wdata, o_rdata, o_dq_out, flash_dq, prot, d;
	logic [7:0]  sh [int];
	logic [31:0] seed = 32'h852F7BCF;
	int          fail_count = 0;
	int          checked = 0;
	int          wcnt = 0;

	// System clock at 25 MHz.
	always #20 i_clk_sys = ~i_clk_sys;

	// Count write strobes issued during one operation.
	always @(negedge o_we_n) wcnt++;

	fcx_host #(.POLL_MAX(8)) u_fcx_host (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_req(i_req), .i_op(i_op),
		.i_addr(i_addr), .i_wdata(i_wdata), .o_busy(o_busy), .o_done(o_done), .o_err(o_err), .o_rdata(o_rdata),
		.o_ce_n(o_ce_n), .o_oe_n(o_oe_n), .o_we_n(o_we_n), .o_addr(o_addr), .o_dq_out(o_dq_out),
		.o_dq_oe(o_dq_oe), .i_dq_in(o_dq_oe ? o_dq_out : flash_dq), .o_id_high_voltage(o_hv));

	fcx_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) u_fcx_flash_model (.i_clk_sys(i_clk_sys),
		.i_ce_n(o_ce_n), .i_oe_n(o_oe_n), .i_we_n(o_we_n), .i_addr(o_addr), .i_dq(o_dq_out),
		.i_id_high_voltage(o_hv), .i_prot(prot), .o_dq(flash_dq));

	// Xorshift source with a fixed seed.
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// Expected array byte: programmed bits cleared, erased bytes all ones.
	function automatic logic [7:0] exp_arr(input logic [16:0] x);
		return sh.exists(x) ? sh[x] : 8'hFF;
	endfunction

	task automatic end_of_test();
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chk_cnt(input string nm, input int e, input int g);
		checked++;
		if (g != e) begin
			fail_count++;
			$display("CHECK FAILED %s expected %0d seen %0d", nm, e, g);
		end
	endtask

	// One command-port operation, waited on with a bound.
	task automatic run(input logic [3:0] op, input logic [16:0] x, input logic [7:0] v);
		int n;
		@(posedge i_clk_sys);
		wcnt = 0;
		i_req <= 1'b1;
		i_op <= op;
		i_addr <= x;
		i_wdata <= v;
		@(posedge i_clk_sys);
		i_req <= 1'b0;
		@(negedge i_clk_sys);
		chk_byte("busy during operation", 8'h01, {7'h00, o_busy});
		n = 0;
		do begin
			@(negedge i_clk_sys);
			n++;
		end while (o_done !== 1'b1 && n < 3000);
		if (n >= 3000) begin
			fail_count++;
			$display("CHECK FAILED done expected pulse seen none");
			end_of_test();
		end
		chk_byte("busy after done", 8'h00, {7'h00, o_busy});
	endtask

	task automatic rd_chk(input logic [16:0] x, input logic [7:0] e);
		run(OP_READ, x, 8'h00);
		chk_byte("read data", e, o_rdata);
	endtask

	// Program, then check strobe count, timeout flag and shadow update.
	task automatic prog(input logic [3:0] op, input logic [16:0] x, input logic [7:0] v, input int n);
		run(op, x, v);
		chk_cnt("write strobes", n, wcnt);
		chk_byte("poll error", 8'h00, {7'h00, o_err});
		if (!prot[x[16:14]]) sh[x] = exp_arr(x) & v;
	endtask

	// Main sequence.
	initial begin
		i_rst_n = 1'b0;
		i_req = 1'b0;
		i_op = 4'h0;
		i_addr = 17'h00000;
		i_wdata = 8'h00;
		prot = 8'h00;
		repeat (10) @(posedge i_clk_sys);
		i_rst_n <= 1'b1;
		rd_chk(17'h1FFFF, 8'hFF);
		for (int k = 0; k < 6; k++) begin
			a = 17'(rnd());
			prog(OP_PROG, a, 8'(rnd()), 4);
			rd_chk(a, exp_arr(a));
		end
		run(OP_BYP_ENTER, 17'h00000, 8'h00);
		for (int k = 0; k < 3; k++) begin
			a = 17'(rnd());
			prog(OP_BYP_PROG, a, 8'(rnd()), 2);
		end
		run(OP_BYP_EXIT, 17'h00000, 8'h00);
		rd_chk(a, exp_arr(a));
		prog(OP_PROG, 17'h03FFF, 8'h12, 4);
		prog(OP_PROG, 17'h04000, 8'h34, 4);
		run(OP_SEC_ERASE, 17'h00000, 8'h00);
		chk_cnt("erase strobes", 6, wcnt);
		run(OP_ADD_SECTOR, 17'h04000, 8'h00);
		chk_cnt("lone sector strobes", 1, wcnt);
		sh[17'h03FFF] = 8'hFF;
		rd_chk(17'h03FFF, 8'hFF);
		rd_chk(17'h04000, exp_arr(17'h04000));
		prog(OP_PROG, 17'h08010, 8'hA5, 4);
		prog(OP_PROG, 17'h14000, 8'h5A, 4);
		run(OP_AUTOSEL, 17'h00000, 8'h00);
		rd_chk({3'd5, 14'h0002}, 8'h00);
		prot = 8'h24;
		rd_chk(17'h00000, MFR);
		rd_chk(17'h00001, DEV);
		for (int s = 0; s < 8; s++) rd_chk({3'(s), 14'h0002}, {7'h00, prot[s]});
		run(OP_RESET, 17'h00000, 8'h00);
		rd_chk(17'h08010, exp_arr(17'h08010));
		run(OP_HV_READ, 17'h00000, 8'h00);
		chk_byte("id high voltage mfr", MFR, o_rdata);
		run(OP_HV_READ, 17'h00001, 8'h00);
		chk_byte("id high voltage dev", DEV, o_rdata);
		run(OP_HV_READ, {3'd5, 14'h0002}, 8'h00);
		chk_byte("id high voltage prot", 8'h01, o_rdata);
		prog(OP_PROG, 17'h08010, 8'h00, 4);
		rd_chk(17'h08010, 8'hA5);
		run(OP_SEC_ERASE, 17'h14000, 8'h00);
		rd_chk(17'h14000, 8'h5A);
		prot = 8'h00;
		prog(OP_PROG, 17'h08010, 8'h0F, 4);
		rd_chk(17'h08010, 8'h05);
		run(OP_CHIP_ERASE, 17'h00000, 8'h00);
		sh.delete();
		rd_chk(17'h14000, 8'hFF);
		for (int k = 0; k < 16; k++) begin
			a = 17'(rnd());
			d = 8'(rnd());
			if (d[0]) prog(OP_PROG, a, d, 4);
			rd_chk(a, exp_arr(a));
		end
		end_of_test();
	end
endmodule
